// [core/chtap_pkg.sv]
// Shared constants and types for the channel tape interface block
package chtap_pkg;
  localparam int unsigned   CHTAP_PHASES      = 8;     // Timing phases T0..T7 in one computer cycle
  localparam logic [2:0]    CHTAP_WIN_START   = 3'h6;  // Window opens at T6
  localparam logic [2:0]    CHTAP_WIN_END     = 3'h3;  // Window closes after T3
  localparam logic [2:0]    CHTAP_PHASE_RST   = 3'h0;
  localparam int unsigned   CHTAP_CHAR_W      = 8;     // Character width, tape frame plus parity
  localparam int unsigned   CHTAP_FIFO_DEPTH  = 16;
  localparam int unsigned   CHTAP_UNIT_W      = 2;     // Unit address bits beyond direction
  localparam logic          CHTAP_DIR_OUT     = 1'b1;  // Direction bit high selects output
  localparam logic [1:0]    CHTAP_MODE_BUF    = 2'h0;  // Buffer control directive
  localparam logic [1:0]    CHTAP_MODE_IO     = 2'h1;  // Input/output directive

  typedef enum logic [1:0]
  {
    CHTAP_IDLE = 2'b00,
    CHTAP_RUN  = 2'b01,
    CHTAP_HALT = 2'b10
  } chtap_state_e;

  // Phase window test, wrapping around the cycle end
  function automatic logic chtap_in_window(input logic [2:0] ph);
    chtap_in_window = (ph >= CHTAP_WIN_START) || (ph <= CHTAP_WIN_END);
  endfunction : chtap_in_window
endpackage : chtap_pkg

// [core/chtap_fifo_if.sv]
// Valid/ready carrier between channel core and character FIFO
`timescale 1ns/10ps
interface chtap_fifo_if #(parameter int unsigned W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport core (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface : chtap_fifo_if

// [core/chtap_fifo.sv]
// Character FIFO built of flip-flops
`timescale 1ns/10ps
module chtap_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic  sys_clk, // System clock
  input  wire logic  rstn,    // Async reset, active low
  input  wire logic  clk_en,  // Freezes state when low
  chtap_fifo_if.fifo f        // Push and pop sides
);
  localparam int unsigned AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("chtap_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  wire logic full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire logic empty = (wr_ptr == rd_ptr);
  wire logic push  = clk_en && f.in_valid && !full;
  wire logic pop   = clk_en && f.out_ready && !empty;

  assign f.in_ready  = !full;
  assign f.out_valid = !empty;
  assign f.out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= f.in_data;
  end
endmodule : chtap_fifo

// [core/chtap_channel.sv]
// Channel side of the tape/character device signal set
`timescale 1ns/10ps

// What this block does
// - Pulse per output directive, buffer mode
// - Pulse per output directive, I/O mode
// - Halt interlock shows character processing reached
// - Transfer-pending flop set when move due
// - Tape-clock-seen flop set on device clock while running
// - Window high from T6 through T3
// - Direction bit high output, low input
// - Unit address bits select peripheral
// - Low response line causes skip
module chtap_channel
  import chtap_pkg::*;
#(
  parameter int unsigned CHAR_W = CHTAP_CHAR_W,
  parameter int unsigned DEPTH  = CHTAP_FIFO_DEPTH,
  parameter int unsigned UNIT_W = CHTAP_UNIT_W
) (
  input  wire logic              sys_clk,                    // System clock, 200 MHz
  input  wire logic              rstn,                       // Async reset, active low
  input  wire logic              clk_en,                     // Freezes system-side state when low
  input  wire logic              tape_clk,                   // Peripheral character clock
  input  wire logic [2:0]        cycle_phase,                // Current computer timing phase
  input  wire logic              directive_stb,              // Output directive executed, one cycle
  input  wire logic [1:0]        directive_mode,             // Mode of that directive
  input  wire logic              directive_start,            // Buffer-mode directive also starts a transfer
  input  wire logic              directive_dir,              // Direction to load into unit address
  input  wire logic [UNIT_W-1:0] directive_unit,             // Unit bits to load
  input  wire logic              skip_on_signal_test,        // Unit test skip instruction, one cycle
  input  wire logic              tape_error_n,               // Error line, low means error
  input  wire logic              tape_gap,                   // Inter-record gap passing
  input  wire logic              tape_halt_n,                // Halt line, low ends process
  input  wire logic              unit_response_n,            // Response line, low means skip
  input  wire logic [CHAR_W-1:0] tape_char_in,               // Character from device
  input  wire logic              word_char_valid,            // Word logic offers an output character
  input  wire logic [CHAR_W-1:0] word_char,                  // That character
  output logic                   word_char_ready,            // Channel accepts output character
  output logic                   read_char_valid,            // Input character for word logic
  output logic [CHAR_W-1:0]      read_char,                  // That character
  input  wire logic              read_char_ready,            // Word logic takes input character
  output logic [CHAR_W-1:0]      tape_char_out,              // Character to device
  output logic                   buffer_ctl_pulse,           // Buffer-mode directive pulse
  output logic                   io_mode_pulse,              // I/O-mode directive pulse
  output logic                   halt_interlock_out,         // Character processing reached
  output logic                   transfer_pending_ff,        // Move to/from word register due
  output logic                   tape_clock_seen_ff,         // Device clock seen
  output logic                   cycle_phase_window,         // T6..T3 window
  output logic                   direction_select,           // High output, low input
  output logic                   unit_select_bit_a,          // Unit address bit
  output logic                   unit_select_bit_b,          // Unit address bit
  output logic                   error_present,              // Tape error seen, synchronised
  output logic                   gap_present,                // Gap seen, synchronised
  output logic                   skip_next                   // Skip the next instruction, one cycle
);
  initial
  begin
    if (UNIT_W != 2 || CHAR_W < 1 || DEPTH < 2)
      $error("chtap_channel: unsupported parameters");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // Idle level of every pin, so no false event follows reset
      pin_s1 <= 4'hb;
      pin_s2 <= 4'hb;
    end
    else if (clk_en)
    begin
      pin_s1 <= {tape_error_n, tape_gap, tape_halt_n, unit_response_n};
      pin_s2 <= pin_s1;
    end
  end
  wire logic err_now  = ~pin_s2[3];
  wire logic gap_now  = pin_s2[2];
  wire logic halt_now = ~pin_s2[1];
  wire logic resp_low = ~pin_s2[0];

  // ----------------------------------------
  // Link domain: capture on rising device clock
  // ----------------------------------------
  // rising edge captures a character
  logic              link_tog;
  logic [CHAR_W-1:0] link_char;
  always_ff @(posedge tape_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link_tog  <= 1'b0;
      link_char <= '0;
    end
    else
    begin
      link_tog  <= ~link_tog;
      link_char <= tape_char_in;
    end
  end

  // Toggle crossing; the char is stable for a whole 197 ns link period once the toggle lands
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_s3;
  wire  logic clk_evt = tog_s2 ^ tog_s3;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end
    else if (clk_en)
    begin
      tog_s1 <= link_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // ----------------------------------------
  // Directive decode and unit address
  // ----------------------------------------
  wire logic dir_buf = directive_stb && (directive_mode == CHTAP_MODE_BUF);
  wire logic dir_io  = directive_stb && (directive_mode == CHTAP_MODE_IO);
  wire logic start   = dir_buf && directive_start;

  chtap_state_e state;
  chtap_state_e next_state;
  always_comb
  begin
    next_state = state;
    unique case (state)
      CHTAP_IDLE: if (start) next_state = CHTAP_RUN;
      CHTAP_RUN:  if (halt_now) next_state = CHTAP_HALT;
      CHTAP_HALT: if (!transfer_pending_ff) next_state = CHTAP_IDLE;
      default:    next_state = CHTAP_IDLE;
    endcase
  end
  wire logic running = (state == CHTAP_RUN);
  wire logic is_out  = (direction_select == CHTAP_DIR_OUT);

  // ----------------------------------------
  // Character FIFO between link and word logic
  // ----------------------------------------
  chtap_fifo_if #(.W(CHAR_W)) fq ();
  chtap_fifo #(.W(CHAR_W), .DEPTH(DEPTH)) u_fifo
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .clk_en  (clk_en),
    .f       (fq)
  );
  // Input: link feeds FIFO; output: word logic feeds FIFO
  wire logic in_take  = running && !is_out && clk_evt;
  // A push only happens where the registered ready promised it
  wire logic out_push = is_out && word_char_valid && word_char_ready;
  assign fq.in_valid  = is_out ? out_push : in_take;
  assign fq.in_data   = is_out ? word_char : link_char;
  // Output characters leave one per device clock
  wire logic out_take = running && is_out && clk_evt;
  assign fq.out_ready = is_out ? out_take : (read_char_ready || !read_char_valid);

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state               <= CHTAP_IDLE;
      buffer_ctl_pulse    <= 1'b0;
      io_mode_pulse       <= 1'b0;
      halt_interlock_out  <= 1'b0;
      transfer_pending_ff <= 1'b0;
      tape_clock_seen_ff  <= 1'b0;
      cycle_phase_window  <= 1'b0;
      direction_select    <= 1'b0;
      unit_select_bit_a   <= 1'b0;
      unit_select_bit_b   <= 1'b0;
      error_present       <= 1'b0;
      gap_present         <= 1'b0;
      skip_next           <= 1'b0;
      word_char_ready     <= 1'b0;
      read_char_valid     <= 1'b0;
      read_char           <= '0;
      tape_char_out       <= '0;
    end
    else if (clk_en)
    begin
      state <= next_state;
      buffer_ctl_pulse <= dir_buf;
      io_mode_pulse <= dir_io;
      cycle_phase_window <= chtap_in_window(cycle_phase);
      error_present      <= err_now;
      gap_present        <= gap_now;
      skip_next          <= skip_on_signal_test && resp_low;
      // Ready rests a cycle after each push: a late ready then never promises a full slot, at half the push rate
      word_char_ready    <= fq.in_ready && is_out && !out_push;
      if (dir_io)
      begin
        direction_select <= directive_dir;
        unit_select_bit_a <= directive_unit[0];
        unit_select_bit_b <= directive_unit[1];
      end
      if (clk_evt && running)
        tape_clock_seen_ff <= 1'b1;
      else if (start)
        tape_clock_seen_ff <= 1'b0;
      transfer_pending_ff <= fq.out_valid && (!is_out || running);
      // processing reached; set wins over clear
      if (running && clk_evt)
        halt_interlock_out <= 1'b1;
      else if (state == CHTAP_IDLE)
        halt_interlock_out <= 1'b0;
      if (out_take && fq.out_valid)
        tape_char_out <= fq.out_data;
      if (!is_out && fq.out_valid && fq.out_ready)
      begin
        read_char_valid <= 1'b1;
        read_char       <= fq.out_data;
      end
      else if (read_char_ready)
        read_char_valid <= 1'b0;
    end
  end
endmodule : chtap_channel

// [verif/chtap_channel_chk.sv]
// Port assertions for the channel tape block
`timescale 1ns/10ps
module chtap_channel_chk
  import chtap_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       clk_en,
  input wire logic [2:0] cycle_phase,
  input wire logic       directive_stb,
  input wire logic [1:0] directive_mode,
  input wire logic       directive_dir,
  input wire logic [1:0] directive_unit,
  input wire logic       skip_on_signal_test,
  input wire logic       tape_error_n,
  input wire logic       tape_gap,
  input wire logic       buffer_ctl_pulse,
  input wire logic       io_mode_pulse,
  input wire logic       cycle_phase_window,
  input wire logic       direction_select,
  input wire logic       unit_select_bit_a,
  input wire logic       unit_select_bit_b,
  input wire logic       error_present,
  input wire logic       gap_present,
  input wire logic       skip_next
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire buf_go = directive_stb && clk_en && directive_mode == CHTAP_MODE_BUF;
  wire io_go  = directive_stb && clk_en && directive_mode == CHTAP_MODE_IO;
  wire in_win = cycle_phase >= CHTAP_WIN_START || cycle_phase <= CHTAP_WIN_END;

  a_buf_pulse: assert property (buf_go |=> buffer_ctl_pulse && !io_mode_pulse)
    else $error("buffer pulse missing");
  a_io_pulse: assert property (io_go |=> io_mode_pulse && !buffer_ctl_pulse)
    else $error("io pulse missing");
  a_pulse_cause: assert property (buffer_ctl_pulse || io_mode_pulse |-> $past(directive_stb))
    else $error("pulse without directive");
  a_phase_window: assert property ($past(rstn) && $past(clk_en) |-> cycle_phase_window == $past(in_win))
    else $error("phase window wrong");
  a_dir_load: assert property (
    io_go |=> direction_select == $past(directive_dir) &&
    {unit_select_bit_b, unit_select_bit_a} == $past(directive_unit))
    else $error("unit address not loaded");
  a_dir_hold: assert property (!io_go |=> $stable(direction_select))
    else $error("direction changed unasked");
  a_skip_cause: assert property (skip_next |-> $past(skip_on_signal_test))
    else $error("skip without test");
  a_err_sync: assert property (!tape_error_n [*5] |-> error_present)
    else $error("error not flagged");
  a_gap_sync: assert property (tape_gap [*5] |-> gap_present)
    else $error("gap not flagged");
endmodule : chtap_channel_chk

bind chtap_channel chtap_channel_chk u_chk (.sys_clk, .rstn, .clk_en, .cycle_phase, .directive_stb,
  .directive_mode, .directive_dir, .directive_unit, .skip_on_signal_test, .tape_error_n, .tape_gap,
  .buffer_ctl_pulse, .io_mode_pulse, .cycle_phase_window, .direction_select, .unit_select_bit_a,
  .unit_select_bit_b, .error_present, .gap_present, .skip_next);

// [verif/chtap_tape_model.sv]
// Tape unit model for the peripheral side
`timescale 1ns/10ps
module chtap_tape_model
  import chtap_pkg::*;
(
  output logic                    tape_clk,       // Idle high
  output logic [CHTAP_CHAR_W-1:0] tape_char_in,   // Character out
  output logic                    tape_error_n,   // Error, low
  output logic                    tape_gap,       // Gap passing
  output logic                    tape_halt_n,    // Halt, low
  output logic                    unit_response_n // Skip, low
);
  initial
  begin
    tape_clk = 1'b1;
    tape_char_in = 8'h00;
    lines(1'b1, 1'b0, 1'b1, 1'b1);
  end

  task automatic lines(input logic e, input logic g, input logic h, input logic r);
    tape_error_n <= e;
    tape_gap <= g;
    tape_halt_n <= h;
    unit_response_n <= r;
  endtask : lines

  // low then high; clock stands still between frames
  task automatic frame(input logic [CHTAP_CHAR_W-1:0] c);
    #37;
    tape_char_in = c;
    tape_clk = 1'b0;
    #80;
    tape_clk = 1'b1;
    #80;
    tape_char_in = ~c;
  endtask : frame
endmodule : chtap_tape_model

// [verif/chtap_channel_bench.sv]
// Self-checking bench for the channel tape block
`timescale 1ns/10ps
module chtap_channel_bench;
  import chtap_pkg::*;
  logic       sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, directive_stb = 1'b0, directive_start = 1'b0;
  logic       directive_dir = 1'b0, skip_on_signal_test = 1'b0, word_char_valid = 1'b0, read_char_ready = 1'b0;
  logic [2:0] cycle_phase = 3'h0;
  logic [1:0] directive_mode = 2'h0, directive_unit = 2'h0;
  logic [7:0] word_char = 8'h00, tape_char_in, tape_char_out, read_char;
  logic       tape_clk, tape_error_n, tape_gap, tape_halt_n, unit_response_n, word_char_ready, read_char_valid;
  logic       buffer_ctl_pulse, io_mode_pulse, halt_interlock_out, transfer_pending_ff, tape_clock_seen_ff;
  logic       cycle_phase_window, direction_select, unit_select_bit_a, unit_select_bit_b, error_present;
  logic       gap_present, skip_next;
  int         fails = 0, check_count = 0, cnt;

  always #2.5 sys_clk = ~sys_clk;

  chtap_channel DUT (.sys_clk, .rstn, .clk_en, .tape_clk, .cycle_phase, .directive_stb, .directive_mode,
    .directive_start, .directive_dir, .directive_unit, .skip_on_signal_test, .tape_error_n, .tape_gap,
    .tape_halt_n, .unit_response_n, .tape_char_in, .word_char_valid, .word_char, .word_char_ready,
    .read_char_valid, .read_char, .read_char_ready, .tape_char_out, .buffer_ctl_pulse, .io_mode_pulse,
    .halt_interlock_out, .transfer_pending_ff, .tape_clock_seen_ff, .cycle_phase_window,
    .direction_select, .unit_select_bit_a, .unit_select_bit_b, .error_present, .gap_present, .skip_next);
  chtap_tape_model u_tape (.tape_clk, .tape_char_in, .tape_error_n, .tape_gap, .tape_halt_n, .unit_response_n);

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic final_report;
    if (fails == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // Bounded wait; returns just after the edge where the level is seen
  task automatic await(ref logic f, input logic v);
    int k;
    for (k = 0; k < 400 && f !== v; k++)
      tick(1);
    if (f !== v)
    begin
      fails++;
      final_report;
    end
  endtask : await

  // Pulses stand one cycle, so they are read just after that edge
  task automatic directive(input logic [1:0] m, input logic s, input logic d, input logic [1:0] u);
    @(posedge sys_clk);
    {directive_stb, directive_mode, directive_start, directive_dir, directive_unit} <= {1'b1, m, s, d, u};
    @(posedge sys_clk);
    {directive_stb, directive_start} <= 2'b00;
    #1;
  endtask : directive

  initial
  begin
    tick(6);
    @(posedge sys_clk);
    rstn <= 1'b1;
    tick(1);
    for (int m = 0; m < 4; m++)
    begin
      directive(m[1:0], 1'b0, 1'b1, 2'h2);
      cmp(buffer_ctl_pulse, m == 0);
      cmp(io_mode_pulse, m == 1);
      cmp(direction_select, m != 0);
      cmp({unit_select_bit_b, unit_select_bit_a}, m ? 2'h2 : 2'h0);
    end
    // A directive while the enable is low must leave no pulse
    clk_en <= 1'b0;
    directive(CHTAP_MODE_BUF, 1'b0, 1'b0, 2'h0);
    cmp(buffer_ctl_pulse, 1'b0);
    clk_en <= 1'b1;
    directive(CHTAP_MODE_IO, 1'b0, 1'b1, 2'h2);
    cmp(io_mode_pulse, 1'b1);
    for (int p = 0; p < 8; p++)
    begin
      @(posedge sys_clk);
      cycle_phase <= p[2:0];
      tick(2);
      cmp(cycle_phase_window, p >= 6 || p <= 3);
    end
    for (int r = 0; r < 2; r++)
    begin
      u_tape.lines(r[0], !r[0], 1'b1, r[0]);
      tick(6);
      skip_on_signal_test <= 1'b1;
      tick(1);
      skip_on_signal_test <= 1'b0;
      cmp(skip_next, !r[0]);
      cmp(error_present, !r[0]);
      cmp(gap_present, !r[0]);
    end
    // Input run with the word logic stalled over two characters
    directive(CHTAP_MODE_IO, 1'b0, 1'b0, 2'h1);
    directive(CHTAP_MODE_BUF, 1'b1, 1'b0, 2'h0);
    u_tape.frame(8'ha5);
    u_tape.frame(8'h3c);
    tick(8);
    cmp(tape_clock_seen_ff, 1'b1);
    cmp(halt_interlock_out, 1'b1);
    cmp(transfer_pending_ff, 1'b1);
    read_char_ready <= 1'b1;
    await(read_char_valid, 1'b1);
    cmp(read_char, 8'ha5);
    tick(1);
    await(read_char_valid, 1'b1);
    cmp(read_char, 8'h3c);
    u_tape.lines(1'b1, 1'b0, 1'b0, 1'b1);
    await(transfer_pending_ff, 1'b0);
    tick(8);
    cmp(halt_interlock_out, 1'b0);
    u_tape.lines(1'b1, 1'b0, 1'b1, 1'b1);
    tick(6);
    // Output run: fill the buffer until refused, then drain it
    directive(CHTAP_MODE_IO, 1'b0, 1'b1, 2'h3);
    directive(CHTAP_MODE_BUF, 1'b1, 1'b1, 2'h0);
    cmp(tape_clock_seen_ff, 1'b0);
    cnt = 0;
    word_char_valid <= 1'b1;
    word_char <= 8'h40;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge sys_clk);
      if (word_char_ready === 1'b1)
      begin
        cnt++;
        word_char <= 8'h40 + cnt[7:0];
      end
    end
    word_char_valid <= 1'b0;
    tick(1);
    cmp(cnt[7:0], 8'(CHTAP_FIFO_DEPTH));
    cmp(word_char_ready, 1'b0);
    cmp(transfer_pending_ff, 1'b1);
    for (int i = 0; i < cnt; i++)
    begin
      u_tape.frame(8'h00);
      tick(8);
      cmp(tape_char_out, 8'h40 + i[7:0]);
    end
    cmp(tape_clock_seen_ff, 1'b1);
    cmp(halt_interlock_out, 1'b1);
    u_tape.lines(1'b1, 1'b0, 1'b0, 1'b1);
    await(transfer_pending_ff, 1'b0);
    tick(8);
    cmp(halt_interlock_out, 1'b0);
    final_report;
  end
endmodule : chtap_channel_bench
